/* accr_pkg.sv */
// Package with the constants, types and carriers of the channel calibration register bank.
package accr_pkg;

  // Bus and word widths.
  localparam int ACCR_ADDR_W = 8;
  localparam int ACCR_IDX_W  = 6;
  localparam int ACCR_REG_W  = 16;
  localparam int ACCR_CAL_W  = 24;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] ACCR_IDX_G3_HIGH = 6'h15;
  localparam logic [5:0] ACCR_IDX_G3_LOW  = 6'h16;
  localparam logic [5:0] ACCR_IDX_CFG     = 6'h18;
  localparam logic [5:0] ACCR_IDX_OCAL_HI = 6'h19;
  localparam logic [5:0] ACCR_IDX_OCAL_LO = 6'h1a;
  localparam logic [5:0] ACCR_IDX_G4_HIGH = 6'h1b;
  localparam logic [5:0] ACCR_IDX_G4_LOW  = 6'h1c;

  // Field positions and writable-bit masks.
  localparam int          ACCR_SEL_LSB    = 0;
  localparam int          ACCR_SEL_MSB    = 1;
  localparam int          ACCR_BYTE_MSB   = 15;
  localparam int          ACCR_BYTE_LSB   = 8;
  localparam logic [15:0] ACCR_CFG_WMASK  = 16'hffc7;
  localparam logic [15:0] ACCR_LOW_WMASK  = 16'hff00;
  localparam logic [15:0] ACCR_FULL_WMASK = 16'hffff;

  // Reset values.
  localparam logic [15:0] ACCR_CFG_RESET       = 16'h0000;
  localparam logic [15:0] ACCR_OCAL_RESET      = 16'h0000;
  localparam logic [15:0] ACCR_GAIN_HIGH_RESET = 16'h8000;
  localparam logic [15:0] ACCR_GAIN_LOW_RESET  = 16'h0000;

  // Input select codes and bus responses.
  localparam logic [1:0] ACCR_MUX_EXT      = 2'h0;
  localparam logic [1:0] ACCR_MUX_SHORT    = 2'h1;
  localparam logic [1:0] ACCR_MUX_TEST_POS = 2'h2;
  localparam logic [1:0] ACCR_MUX_TEST_NEG = 2'h3;
  localparam logic [1:0] ACCR_RESP_OKAY    = 2'h0;
  localparam logic [1:0] ACCR_RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    ACCR_SEL_NONE, ACCR_SEL_G3_HIGH, ACCR_SEL_G3_LOW, ACCR_SEL_CFG,
    ACCR_SEL_OCAL_HI, ACCR_SEL_OCAL_LO, ACCR_SEL_G4_HIGH, ACCR_SEL_G4_LOW
  } accr_reg_sel_type;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } accr_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } accr_axi_rsp_type;

  typedef struct packed {
    logic connect_ext;
    logic short_inputs;
    logic test_pos;
    logic test_neg;
  } accr_route_type;

  localparam accr_route_type ACCR_ROUTE_RESET = 4'h8;

endpackage : accr_pkg

/* accr_input_route.sv */
// Decoder from the channel-four input select field to the analog routing controls.
`timescale 1ns/1ps
`default_nettype none
module accr_input_route (
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic [1:0]               input_select,
  output var  accr_pkg::accr_route_type route
);
  import accr_pkg::*;

  typedef struct packed {
    accr_route_type route;
  } accr_route_state_type;

  accr_route_state_type st_reg;
  accr_route_state_type st_next;

  // One control is high for each select code.
  always_comb begin
    st_next = '0;
    case (input_select)
      ACCR_MUX_EXT:      st_next.route.connect_ext = 1'b1;
      ACCR_MUX_SHORT:    st_next.route.short_inputs = 1'b1;
      ACCR_MUX_TEST_POS: st_next.route.test_pos = 1'b1;
      default:           st_next.route.test_neg = 1'b1;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg.route <= ACCR_ROUTE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign route = st_reg.route;

  a_route_ext: assert property (@(posedge ref_clk) disable iff (!resetn)
    input_select == ACCR_MUX_EXT |=> route == 4'h8)
    else $error("external pins not routed");
  a_route_short: assert property (@(posedge ref_clk) disable iff (!resetn)
    input_select == ACCR_MUX_SHORT |=> route == 4'h4)
    else $error("inputs not shorted");
  a_route_pos: assert property (@(posedge ref_clk) disable iff (!resetn)
    input_select == ACCR_MUX_TEST_POS |=> route == 4'h2)
    else $error("positive test signal not routed");
  a_route_neg: assert property (@(posedge ref_clk) disable iff (!resetn)
    input_select == ACCR_MUX_TEST_NEG |=> route == 4'h1)
    else $error("negative test signal not routed");

endmodule : accr_input_route
`default_nettype wire

/* accr_gain_scale.sv */
// Scaler that multiplies a signed sample by an unsigned fractional gain word.
`timescale 1ns/1ps
`default_nettype none
module accr_gain_scale #(
  parameter int DATA_W = 24
) (
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic signed [DATA_W-1:0] sample,
  input  wire logic [DATA_W-1:0]  gain,
  output var  logic signed [DATA_W-1:0] scaled
);
  import accr_pkg::*;

  if (DATA_W < 2 || DATA_W > 32) begin : g_bad_width
    $error("accr_gain_scale: DATA_W must lie in 2..32");
  end

  typedef struct packed {
    logic signed [DATA_W-1:0] scaled;
  } accr_scale_state_type;

  accr_scale_state_type   st_reg;
  accr_scale_state_type   st_next;
  logic signed [2*DATA_W:0] prod;
  logic signed [2*DATA_W:0] shifted;
  logic signed [2*DATA_W:0] maxv;
  logic signed [2*DATA_W:0] minv;

  // Unsigned fraction with unity at the top bit.
  always_comb begin
    prod    = sample * $signed({1'b0, gain});
    shifted = prod >>> (DATA_W - 1);
    maxv    = {{(DATA_W + 2){1'b0}}, {(DATA_W - 1){1'b1}}};
    minv    = {{(DATA_W + 2){1'b1}}, {(DATA_W - 1){1'b0}}};
    st_next = st_reg;
    if (shifted > maxv) begin
      st_next.scaled = maxv[DATA_W-1:0];
    end else if (shifted < minv) begin
      st_next.scaled = minv[DATA_W-1:0];
    end else begin
      st_next.scaled = shifted[DATA_W-1:0];
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign scaled = st_reg.scaled;

  a_gain_unity: assert property (@(posedge ref_clk) disable iff (!resetn)
    gain == {1'b1, {(DATA_W - 1){1'b0}}} |=> scaled == $past(sample))
    else $error("unity gain changed the sample");
  a_gain_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    gain == '0 |=> scaled == '0)
    else $error("zero gain gave a nonzero result");

endmodule : accr_gain_scale
`default_nettype wire

/* accr_regs.sv */
// Register bank for the channel-four input and offset words and the gain words, on AXI4-Lite.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module accr_regs (
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  input  wire accr_pkg::accr_axi_req_type s_axi_req,
  output var  accr_pkg::accr_axi_rsp_type s_axi_rsp,
  input  wire logic signed [23:0]         chan3_sample,
  input  wire logic signed [23:0]         chan4_sample,
  output var  logic [1:0]                 chan4_input_select,
  output var  accr_pkg::accr_route_type   chan4_route,
  output var  logic signed [23:0]         chan4_offset,
  output var  logic [23:0]                chan3_gain,
  output var  logic [23:0]                chan4_gain,
  output var  logic signed [23:0]         chan3_scaled,
  output var  logic signed [23:0]         chan4_scaled
);
  import accr_pkg::*;

  typedef struct packed {
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [15:0] w_data;
    logic [1:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] cfg;
    logic [15:0] ocal_hi;
    logic [15:0] ocal_lo;
    logic [15:0] g3_hi;
    logic [15:0] g3_lo;
    logic [15:0] g4_hi;
    logic [15:0] g4_lo;
  } accr_regs_state_type;

  accr_regs_state_type st_reg;
  accr_regs_state_type st_next;
  accr_reg_sel_type    wr_sel;
  accr_reg_sel_type    rd_sel;
  logic                wr_commit;
  logic                rd_take;

  // Maps a byte address to the register it names.
  function automatic accr_reg_sel_type reg_decode(
    input logic [ACCR_ADDR_W-1:0] addr
  );
    logic [ACCR_IDX_W-1:0] idx;
    idx = addr[ACCR_ADDR_W-1:2];
    if (idx == ACCR_IDX_G3_HIGH) begin
      reg_decode = ACCR_SEL_G3_HIGH;
    end else if (idx == ACCR_IDX_G3_LOW) begin
      reg_decode = ACCR_SEL_G3_LOW;
    end else if (idx == ACCR_IDX_CFG) begin
      reg_decode = ACCR_SEL_CFG;
    end else if (idx == ACCR_IDX_OCAL_HI) begin
      reg_decode = ACCR_SEL_OCAL_HI;
    end else if (idx == ACCR_IDX_OCAL_LO) begin
      reg_decode = ACCR_SEL_OCAL_LO;
    end else if (idx == ACCR_IDX_G4_HIGH) begin
      reg_decode = ACCR_SEL_G4_HIGH;
    end else if (idx == ACCR_IDX_G4_LOW) begin
      reg_decode = ACCR_SEL_G4_LOW;
    end else begin
      reg_decode = ACCR_SEL_NONE;
    end
  endfunction : reg_decode

  // Applies byte strobes, then clears every bit that software cannot write.
  function automatic logic [15:0] reg_merge(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0]  strb,
    input logic [15:0] wmask
  );
    logic [15:0] m;
    m = old;
    if (strb[0]) begin
      m[7:0] = data[7:0];
    end
    if (strb[1]) begin
      m[15:8] = data[15:8];
    end
    reg_merge = m & wmask;
  endfunction : reg_merge

  // Decode of the held write address and the offered read address.
  assign wr_sel    = reg_decode(st_reg.aw_addr);
  assign rd_sel    = reg_decode(s_axi_req.araddr);
  assign wr_commit = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid;
  assign rd_take   = s_axi_req.arvalid && !st_reg.rvalid;

  // Next state of the bus slave and of the register words.
  always_comb begin
    st_next = st_reg;
    // Address and data are caught independently, in either order.
    if (s_axi_req.awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_req.wdata[15:0];
      st_next.w_strb = s_axi_req.wstrb[1:0];
    end
    if (st_reg.bvalid && s_axi_req.bready) begin
      st_next.bvalid = 1'b0;
    end
    // A write lands once both halves are held and no response is pending.
    if (wr_commit) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = ACCR_RESP_OKAY;
      case (wr_sel)
        ACCR_SEL_G3_HIGH: begin
          st_next.g3_hi = reg_merge(st_reg.g3_hi, st_reg.w_data, st_reg.w_strb,
                                    ACCR_FULL_WMASK);
        end
        ACCR_SEL_G3_LOW: begin
          // Gain low byte, low lane dropped.
          st_next.g3_lo = reg_merge(st_reg.g3_lo, st_reg.w_data, st_reg.w_strb,
                                    ACCR_LOW_WMASK);
        end
        ACCR_SEL_CFG: begin
          // Bits 5:3 dropped, bits 15:6 and 2:0 kept as written.
          st_next.cfg = reg_merge(st_reg.cfg, st_reg.w_data, st_reg.w_strb,
                                  ACCR_CFG_WMASK);
        end
        ACCR_SEL_OCAL_HI: begin
          st_next.ocal_hi = reg_merge(st_reg.ocal_hi, st_reg.w_data, st_reg.w_strb,
                                      ACCR_FULL_WMASK);
        end
        ACCR_SEL_OCAL_LO: begin
          // Offset bits 7:0 in the upper lane.
          st_next.ocal_lo = reg_merge(st_reg.ocal_lo, st_reg.w_data, st_reg.w_strb,
                                      ACCR_LOW_WMASK);
        end
        ACCR_SEL_G4_HIGH: begin
          st_next.g4_hi = reg_merge(st_reg.g4_hi, st_reg.w_data, st_reg.w_strb,
                                    ACCR_FULL_WMASK);
        end
        ACCR_SEL_G4_LOW: begin
          st_next.g4_lo = reg_merge(st_reg.g4_lo, st_reg.w_data, st_reg.w_strb,
                                    ACCR_LOW_WMASK);
        end
        default: begin
          st_next.bresp = ACCR_RESP_SLVERR;
        end
      endcase
    end
    // Read data is latched when the address is taken and held until rready.
    if (st_reg.rvalid && s_axi_req.rready) begin
      st_next.rvalid = 1'b0;
    end
    if (rd_take) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = ACCR_RESP_OKAY;
      st_next.rdata  = '0;
      case (rd_sel)
        ACCR_SEL_G3_HIGH: st_next.rdata[15:0] = st_reg.g3_hi;
        ACCR_SEL_G3_LOW:  st_next.rdata[15:0] = st_reg.g3_lo;
        ACCR_SEL_CFG:     st_next.rdata[15:0] = st_reg.cfg;
        ACCR_SEL_OCAL_HI: st_next.rdata[15:0] = st_reg.ocal_hi;
        ACCR_SEL_OCAL_LO: st_next.rdata[15:0] = st_reg.ocal_lo;
        ACCR_SEL_G4_HIGH: st_next.rdata[15:0] = st_reg.g4_hi;
        ACCR_SEL_G4_LOW:  st_next.rdata[15:0] = st_reg.g4_lo;
        default:          st_next.rresp       = ACCR_RESP_SLVERR;
      endcase
    end
  end

  // State register; the register words take their reset values.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg         <= '0;
      st_reg.cfg     <= ACCR_CFG_RESET;
      st_reg.ocal_hi <= ACCR_OCAL_RESET;
      st_reg.ocal_lo <= ACCR_OCAL_RESET;
      // Gain high words reset to unity.
      st_reg.g3_hi   <= ACCR_GAIN_HIGH_RESET;
      st_reg.g4_hi   <= ACCR_GAIN_HIGH_RESET;
      st_reg.g3_lo   <= ACCR_GAIN_LOW_RESET;
      st_reg.g4_lo   <= ACCR_GAIN_LOW_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Bus handshake outputs; ready is high while the matching holder is free.
  always_comb begin
    s_axi_rsp.awready = !st_reg.aw_held;
    s_axi_rsp.wready  = !st_reg.w_held;
    s_axi_rsp.bvalid  = st_reg.bvalid;
    s_axi_rsp.bresp   = st_reg.bresp;
    s_axi_rsp.arready = !st_reg.rvalid;
    s_axi_rsp.rvalid  = st_reg.rvalid;
    s_axi_rsp.rdata   = st_reg.rdata;
    s_axi_rsp.rresp   = st_reg.rresp;
  end

  // Input select from configuration bits 1:0; calibration words assembled from their high and low registers.
  assign chan4_input_select = st_reg.cfg[ACCR_SEL_MSB:ACCR_SEL_LSB];
  // Signed offset, high word over low byte.
  assign chan4_offset = {st_reg.ocal_hi, st_reg.ocal_lo[ACCR_BYTE_MSB:ACCR_BYTE_LSB]};
  assign chan3_gain   = {st_reg.g3_hi, st_reg.g3_lo[ACCR_BYTE_MSB:ACCR_BYTE_LSB]};
  assign chan4_gain   = {st_reg.g4_hi, st_reg.g4_lo[ACCR_BYTE_MSB:ACCR_BYTE_LSB]};

  // Routing decode for the channel-four input.
  accr_input_route u_route (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .input_select (chan4_input_select),
    .route        (chan4_route)
  );

  // Gain scaling of the two channels.
  accr_gain_scale #(
    .DATA_W (ACCR_CAL_W)
  ) u_scale3 (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .sample  (chan3_sample),
    .gain    (chan3_gain),
    .scaled  (chan3_scaled)
  );

  accr_gain_scale #(
    .DATA_W (ACCR_CAL_W)
  ) u_scale4 (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .sample  (chan4_sample),
    .gain    (chan4_gain),
    .scaled  (chan4_scaled)
  );

  a_cfg_reset_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(resetn) |-> st_reg.cfg == ACCR_CFG_RESET && chan4_input_select == 2'h0)
    else $error("configuration not zero after reset");

  a_cfg_read_back: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_take && rd_sel == ACCR_SEL_CFG |=>
      s_axi_rsp.rvalid && s_axi_rsp.rdata == {16'h0000, $past(st_reg.cfg)})
    else $error("configuration read returned a wrong word");

  a_ocal_reset_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(resetn) |-> chan4_offset == 24'h000000)
    else $error("offset not zero after reset");

  a_ocal_high_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_commit && wr_sel == ACCR_SEL_OCAL_HI && st_reg.w_strb == 2'h3 |=>
      chan4_offset[23:8] == $past(st_reg.w_data) && s_axi_rsp.bvalid)
    else $error("offset high word not stored");

  a_ocal_low_byte: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_commit && wr_sel == ACCR_SEL_OCAL_LO && st_reg.w_strb[1] |=>
      chan4_offset[7:0] == $past(st_reg.w_data[15:8]) && st_reg.ocal_lo[7:0] == 8'h00)
    else $error("offset low byte not stored");

  a_gain3_low_byte: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_commit && wr_sel == ACCR_SEL_G3_LOW && st_reg.w_strb[1] |=>
      chan3_gain[7:0] == $past(st_reg.w_data[15:8]) && chan3_gain[23:8] == $past(st_reg.g3_hi))
    else $error("gain low byte not stored");

  a_gain_unity_reset: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(resetn) |-> chan3_gain == 24'h800000 && chan4_gain == 24'h800000)
    else $error("gain words not unity after reset");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_axi_rsp.rvalid && $past(rd_take) && ($past(rd_sel) == ACCR_SEL_OCAL_LO ||
      $past(rd_sel) == ACCR_SEL_G3_LOW || $past(rd_sel) == ACCR_SEL_G4_LOW) |->
      s_axi_rsp.rdata[7:0] == 8'h00)
    else $error("reserved low byte read nonzero");

  a_cfg_ro_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_take && rd_sel == ACCR_SEL_CFG |=>
      s_axi_rsp.rdata[5:3] == 3'h0 && st_reg.cfg[5:3] == 3'h0)
    else $error("configuration bits 5:3 read nonzero");

  a_unmapped_err: assert property (@(posedge ref_clk) disable iff (!resetn)
    rd_take && rd_sel == ACCR_SEL_NONE |=>
      s_axi_rsp.rresp == ACCR_RESP_SLVERR && s_axi_rsp.rdata == 32'h00000000)
    else $error("unmapped read not refused");

endmodule : accr_regs
`default_nettype wire

/* test_adc_channel_cal_config_regs.sv */
// Self-checking testbench of the channel calibration register bank on AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module test_adc_channel_cal_config_regs;
  import accr_pkg::*;

  logic                     ref_clk;
  logic                     resetn;
  accr_axi_req_type         req;
  accr_axi_rsp_type         rsp;
  accr_axi_rsp_type         snap;
  logic signed [23:0]       s3;
  logic signed [23:0]       s4;
  logic [1:0]               sel;
  accr_route_type           route;
  logic signed [23:0]       offs;
  logic [23:0]              g3;
  logic [23:0]              g4;
  logic signed [23:0]       sc3;
  logic signed [23:0]       sc4;
  logic [15:0]              mdl [int];
  logic [31:0]              seed;
  logic [7:0]               amap [7];
  int                       err_total;
  int                       checks_done;
  int                       cyc;

  accr_regs accr_regs_i (
    .ref_clk            (ref_clk),
    .resetn             (resetn),
    .s_axi_req          (req),
    .s_axi_rsp          (rsp),
    .chan3_sample       (s3),
    .chan4_sample       (s4),
    .chan4_input_select (sel),
    .chan4_route        (route),
    .chan4_offset       (offs),
    .chan3_gain         (g3),
    .chan4_gain         (g4),
    .chan3_scaled       (sc3),
    .chan4_scaled       (sc4)
  );

  // The clock runs at 20 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Outputs are copied mid-cycle so the task sees the values held before each edge.
  always @(negedge ref_clk) snap = rsp;

  // A hang is cut short after a fixed number of cycles.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      results();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Writable bits of each register; read-only bits stay zero.
  function automatic logic [15:0] msk(input logic [7:0] a);
    if (a == 8'h60) return 16'hffc7;
    if (a == 8'h58 || a == 8'h68 || a == 8'h70) return 16'hff00;
    return 16'hffff;
  endfunction : msk

  // Fractional gain product, saturated to the signed 24-bit range.
  function automatic logic [23:0] scl(input logic [23:0] s, input logic [23:0] g);
    longint p;
    p = (longint'(signed'(s)) * longint'({8'h00, g})) >>> 23;
    if (p > 64'sd8388607) p = 64'sd8388607;
    if (p < -64'sd8388608) p = -64'sd8388608;
    return p[23:0];
  endfunction : scl

  task automatic init_mdl();
    foreach (amap[i]) mdl[amap[i]] = 16'h0000;
    mdl[8'h54] = 16'h8000;
    mdl[8'h6c] = 16'h8000;
  endtask : init_mdl

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= {16'h0000, d};
    req.wstrb   <= 4'hf;
    req.wvalid  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (snap.awready && req.awvalid) req.awvalid <= 1'b0;
      if (snap.wready && req.wvalid) req.wvalid <= 1'b0;
    end while (!snap.bvalid);
    r = snap.bresp;
  endtask : wr

  task automatic rdchk(input logic [7:0] a);
    logic [31:0] e;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (snap.arready && req.arvalid) req.arvalid <= 1'b0;
    end while (!snap.rvalid);
    e = 32'h0;
    if (mdl.exists(a)) e = {16'h0000, mdl[a]};
    chk(snap.rdata, e, "rdata");
    chk({30'h0, snap.rresp}, mdl.exists(a) ? 32'h0 : 32'h2, "rresp");
  endtask : rdchk

  task automatic outchk();
    chk({30'h0, sel}, {30'h0, mdl[8'h60][1:0]}, "select");
    chk({8'h0, offs}, {8'h0, mdl[8'h64], mdl[8'h68][15:8]}, "offset");
    chk({8'h0, g3}, {8'h0, mdl[8'h54], mdl[8'h58][15:8]}, "gain3");
    chk({8'h0, g4}, {8'h0, mdl[8'h6c], mdl[8'h70][15:8]}, "gain4");
  endtask : outchk

  task automatic wrchk(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, mdl.exists(a) ? 32'h0 : 32'h2, "bresp");
    if (mdl.exists(a)) mdl[a] = (mdl[a] & ~msk(a)) | (d & msk(a));
    @(negedge ref_clk);
    outchk();
    @(posedge ref_clk);
    rdchk(a);
  endtask : wrchk

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    init_mdl();
    foreach (amap[i]) rdchk(amap[i]);
  endtask : do_reset

  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  initial begin
    logic [15:0] d;
    logic [7:0]  a;
    amap = '{8'h54, 8'h58, 8'h60, 8'h64, 8'h68, 8'h6c, 8'h70};
    req        = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    resetn     = 1'b0;
    s3         = 24'h000000;
    s4         = 24'h000000;
    seed       = 32'hfc048e77;
    err_total  = 0;
    checks_done = 0;
    cyc        = 0;
    do_reset();
    // Random writes across the map, read back and seen at the outputs.
    repeat (30) begin
      seed = lfsr(seed);
      a = amap[seed % 7];
      d = seed[31:16];
      if (a == 8'h60) d = d & 16'h003b;
      wrchk(a, d);
    end
    // Each select code routes the channel-four inputs one way only.
    for (int c = 0; c < 4; c++) begin
      wrchk(8'h60, 16'h0038 | 16'(c));
      @(negedge ref_clk);
      chk({28'h0, route}, 32'h8 >> c, "route");
      @(posedge ref_clk);
    end
    // Unmapped places answer with an error and change nothing.
    wrchk(8'h40, 16'hffff);
    rdchk(8'h40);
    rdchk(8'h74);
    // Scaling with the random gains, then with unity gain on channel three.
    for (int k = 0; k < 16; k++) begin
      if (k == 8) wrchk(8'h54, 16'h8000);
      if (k == 8) wrchk(8'h58, 16'h0000);
      // Zero gain on channel four from here on.
      if (k == 12) wrchk(8'h6c, 16'h0000);
      if (k == 12) wrchk(8'h70, 16'h0000);
      seed = lfsr(seed);
      s3 <= (k == 3) ? 24'h7fffff : seed[23:0];
      s4 <= (k == 4) ? 24'h800000 : seed[31:8];
      repeat (3) @(negedge ref_clk);
      chk({8'h0, sc3}, {8'h0, scl(s3, g3)}, "scaled3");
      chk({8'h0, sc4}, {8'h0, scl(s4, g4)}, "scaled4");
      @(posedge ref_clk);
    end
    // A second reset at the end of the run restores every register.
    do_reset();
    results();
  end

endmodule : test_adc_channel_cal_config_regs
`default_nettype wire
